// *** pkg/fpec_pkg.sv ***
package fpec_pkg;
  // Command codes
  localparam logic [7:0] CMD_LOCK = 8'h00;
  localparam logic [7:0] CMD_UNLOCK1 = 8'h73;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h8c;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CMD = 8'h60;
  localparam logic [7:0] IDX_CTRL = 8'h61;
  localparam logic [7:0] IDX_SECT = 8'h62;
  localparam logic [7:0] IDX_PAGE = 8'h63;
  localparam logic [7:0] IDX_FREQ = 8'h64;
  localparam logic [7:0] IDX_OPT = 8'h65;
  localparam logic [11:0] ADDR_CMD = {2'b00, IDX_CMD, 2'b00};
  localparam logic [11:0] ADDR_CTRL = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [11:0] ADDR_SECT = {2'b00, IDX_SECT, 2'b00};
  localparam logic [11:0] ADDR_PAGE = {2'b00, IDX_PAGE, 2'b00};
  localparam logic [11:0] ADDR_FREQ = {2'b00, IDX_FREQ, 2'b00};
  localparam logic [11:0] ADDR_OPT = {2'b00, IDX_OPT, 2'b00};
  // Field positions
  localparam int STAT_UNLOCK_BIT = 7;
  localparam int CTRL_INFO_BIT = 7;
  localparam int OPT_WP_BIT = 0;
  localparam int OPT_RP_BIT = 1;
  localparam int OPT_BYP_BIT = 2;
  // Status codes of the six-bit state field
  localparam logic [5:0] STAT_IDLE = 6'h00;
  localparam logic [5:0] STAT_PROG = 6'h08;
  localparam logic [5:0] STAT_PAGE = 6'h10;
  localparam logic [5:0] STAT_MASS = 6'h20;
  // Reset values
  localparam logic [7:0] SECT_RST = 8'h00;
  localparam logic [15:0] PAGE_RST = 16'h0000;
  localparam logic [15:0] FREQ_RST = 16'h0000;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  // Timing: operation times in microseconds; cycles = time_us * khz / 1000, rounded up
  localparam int unsigned PROG_TIME_US = 40;
  localparam int unsigned PAGE_ERASE_TIME_US = 10000;
  localparam int unsigned MASS_ERASE_TIME_US = 10000;
  localparam int unsigned KHZ_US_DIV = 1000;
  // Operation kinds for the timer
  localparam logic [1:0] OP_PROG = 2'h0;
  localparam logic [1:0] OP_PAGE = 2'h1;
  localparam logic [1:0] OP_MASS = 2'h2;
  typedef enum logic [2:0] {
    ST_LOCKED, ST_PAGE_SET, ST_FIRST_KEY, ST_UNLOCKED, ST_PROG, ST_PAGE_ERASE, ST_MASS_ERASE
  } fpec_state_e;
endpackage

// *** hdl/fpec_sync.sv ***
`timescale 1ns/1ps
module fpec_sync #(
  parameter int W = 1
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic [W-1:0] d, // Asynchronous input
  output logic [W-1:0] q // Synchronised output
);
  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// *** hdl/fpec_op_timer.sv ***
`timescale 1ns/1ps
module fpec_op_timer #(
  parameter int unsigned PROG_US = fpec_pkg::PROG_TIME_US,
  parameter int unsigned PAGE_US = fpec_pkg::PAGE_ERASE_TIME_US,
  parameter int unsigned MASS_US = fpec_pkg::MASS_ERASE_TIME_US
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic start, // One-cycle start pulse
  input wire logic [1:0] kind, // Operation kind
  input wire logic [15:0] khz, // Clock frequency in kHz
  output logic done // One-cycle pulse at the end of the operation
);
  logic [31:0] time_us;
  logic [47:0] need;
  logic [31:0] cycles;
  logic [31:0] cnt;
  logic running;

  // Least time, so the cycle count rounds up; never below one cycle
  always_comb
  begin
    unique case (kind)
      fpec_pkg::OP_PROG: time_us = 32'(PROG_US);
      fpec_pkg::OP_PAGE: time_us = 32'(PAGE_US);
      default: time_us = 32'(MASS_US);
    endcase
    need = (48'(time_us) * 48'(khz) + 48'(fpec_pkg::KHZ_US_DIV - 1))
      / 48'(fpec_pkg::KHZ_US_DIV);
    cycles = (need == 48'h0) ? 32'h1 : need[31:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 32'h0;
      running <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        cnt <= cycles;
        running <= 1'b1;
      end
      else if (running)
      begin
        if (cnt == 32'h1)
        begin
          running <= 1'b0;
          done <= 1'b1;
        end
        cnt <= cnt - 32'h1;
      end
    end
  end
endmodule

// *** hdl/fpec_top.sv ***
`timescale 1ns/1ps
// Functional notes
// - Reset leaves the controller locked; nothing is programmed or erased.
// - Any out-of-sequence command or page-select write relocks the controller.
// - Unlock is page select, then command 73H, then command 8CH.
// - Read-protect option hides user code from debugger and bypass reads.
// - Sector protect clears at reset; user writes only set bits.
// - Write-protect option blocks every user program and erase.
// - Unlocked, a word write inside the selected page programs that word.
// - Programming is by 16-bit word; a lone byte waits for its partner.
// - Reads stall and interrupts wait while programming runs.
// - Command 00H ends programming and relocks.
// - User writes outside the selected page or in protected sectors are ignored.
// - After unlock, command 95H erases the selected 2 KB page.
// - Page erase stalls reads, defers interrupts, then relocks on completion.
// - User page erase only proceeds in a sector whose protect bit is clear.
// - User code can never start a whole-array erase.
// - Bypass mode hands array control signals to general-purpose pins.
// - Debugger skips unlock, protect bits, option write-protect and page limit.
// - Debugger may write sector protect bits to zero or one.
// - Debugger may write page select while unlocked; whole-array erase allowed.
// - Command 63H is whole-array erase; unknown codes lock the controller.
// - Status shows idle, programming, page or mass erase, plus unlock bit.
module fpec_top #(
  parameter int unsigned PROG_TIME_US = fpec_pkg::PROG_TIME_US,
  parameter int unsigned PAGE_ERASE_TIME_US = fpec_pkg::PAGE_ERASE_TIME_US,
  parameter int unsigned MASS_ERASE_TIME_US = fpec_pkg::MASS_ERASE_TIME_US,
  parameter int PAGE_W = 6,
  parameter int PAGE_WORDS_LOG2 = 10,
  parameter int SECT_SHIFT = 3
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic dbg_access, // Register access comes from the debugger
  input wire logic wp_option, // Write-protect option bit
  input wire logic rp_option, // Read-protect option bit
  input wire logic mem_we, // Program memory write strobe
  input wire logic mem_dbg, // Memory write comes from the debugger
  input wire logic [15:0] mem_waddr, // Program memory word address
  input wire logic [15:0] mem_wdata, // Program memory write data
  input wire logic [1:0] mem_be, // Byte enables, bit 0 low byte
  output logic mem_wait, // Flash reads and fetches held in wait
  output logic irq_hold, // Interrupt service deferred
  output logic info_sel, // Information area selected
  output logic [15:0] fl_addr, // Array word address
  output logic [15:0] fl_wdata, // Array program data
  output logic fl_prog, // Array program strobe
  output logic fl_erase, // Array page erase strobe
  output logic fl_mass, // Array mass erase strobe
  input wire logic [15:0] fl_rdata, // Array read data
  output logic [15:0] dbg_rdata, // Read data toward the debugger
  input wire logic bypass_pin, // Bypass mode select pin
  input wire logic byp_prog_pin, // Bypass program pin
  input wire logic byp_erase_pin, // Bypass page erase pin
  input wire logic byp_mass_pin, // Bypass mass erase pin
  input wire logic [15:0] byp_addr_pin, // Bypass address pins
  input wire logic [15:0] byp_wdata_pin, // Bypass data pins
  output logic [15:0] byp_rdata // Read data toward bypass pins
);
  fpec_pkg::fpec_state_e state;
  logic [7:0] sect;
  logic [15:0] page;
  logic [15:0] freq_khz;
  logic ret_unlocked;
  logic pend_valid;
  logic pend_hi;
  logic [15:0] pend_addr;
  logic [7:0] pend_byte;
  logic op_done;
  logic op_start;
  logic [1:0] op_kind;
  logic [35:0] byp_sync;
  logic bypass;
  logic wr_acc;
  logic cmd_wr;
  logic page_wr;
  logic sect_wr;
  logic busy;
  logic [7:0] cmd;
  logic [PAGE_W-1:0] page_sel;
  logic page_sect_prot;
  logic word_full;
  logic [15:0] word_data;
  logic prog_ok;
  logic prog_start;
  logic erase_start;
  logic mass_start;
  logic [5:0] stat_code;
  logic unlock_flag;
  logic mapped;

  fpec_sync #(.W(36)) u_byp_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({bypass_pin, byp_prog_pin, byp_erase_pin, byp_mass_pin, byp_addr_pin, byp_wdata_pin}),
    .q(byp_sync)
  );
  assign bypass = byp_sync[35];

  fpec_op_timer #(
    .PROG_US(PROG_TIME_US),
    .PAGE_US(PAGE_ERASE_TIME_US),
    .MASS_US(MASS_ERASE_TIME_US)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(op_start),
    .kind(op_kind),
    .khz(freq_khz),
    .done(op_done)
  );

  always_comb
  begin
    wr_acc = psel && penable && pwrite && pready;
    cmd_wr = wr_acc && (paddr == fpec_pkg::ADDR_CMD);
    page_wr = wr_acc && (paddr == fpec_pkg::ADDR_PAGE);
    sect_wr = wr_acc && (paddr == fpec_pkg::ADDR_SECT);
    cmd = pwdata[7:0];
    busy = (state == fpec_pkg::ST_PROG) || (state == fpec_pkg::ST_PAGE_ERASE)
      || (state == fpec_pkg::ST_MASS_ERASE);
    page_sel = page[PAGE_W-1:0];
    page_sect_prot = sect[3'(page_sel >> SECT_SHIFT)];
    mapped = (paddr == fpec_pkg::ADDR_CMD) || (paddr == fpec_pkg::ADDR_CTRL)
      || (paddr == fpec_pkg::ADDR_SECT) || (paddr == fpec_pkg::ADDR_PAGE)
      || (paddr == fpec_pkg::ADDR_FREQ) || (paddr == fpec_pkg::ADDR_OPT);
  end

  // Word assembly: full word, or a lone byte meeting its partner
  always_comb
  begin
    word_full = 1'b0;
    word_data = mem_wdata;
    if (mem_be == 2'b11)
      word_full = 1'b1;
    else if (pend_valid && (pend_addr == mem_waddr) && (pend_hi != mem_be[1]) && (mem_be != 2'b00))
    begin
      word_full = 1'b1;
      word_data = pend_hi ? {pend_byte, mem_wdata[7:0]} : {mem_wdata[15:8], pend_byte};
    end
  end

  // Program permission: the debugger ignores lock, page and protection
  always_comb
  begin
    if (mem_dbg)
      prog_ok = !busy;
    else
      prog_ok = (state == fpec_pkg::ST_UNLOCKED) && !wp_option
        && (mem_waddr[PAGE_WORDS_LOG2 +: PAGE_W] == page_sel)
        && !page_sect_prot;
    prog_start = mem_we && !bypass && word_full && prog_ok;
  end

  always_comb
  begin
    erase_start = 1'b0;
    mass_start = 1'b0;
    if (cmd_wr && !busy)
    begin
      if (dbg_access)
      begin
        erase_start = (cmd == fpec_pkg::CMD_PAGE_ERASE);
        mass_start = (cmd == fpec_pkg::CMD_MASS_ERASE);
      end
      else
      begin
        erase_start = (state == fpec_pkg::ST_UNLOCKED) && (cmd == fpec_pkg::CMD_PAGE_ERASE)
          && !wp_option && !page_sect_prot;
      end
    end
    op_start = prog_start || erase_start || mass_start;
    op_kind = mass_start ? fpec_pkg::OP_MASS
      : (erase_start ? fpec_pkg::OP_PAGE : fpec_pkg::OP_PROG);
  end

  // Controller sequence
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= fpec_pkg::ST_LOCKED;
      ret_unlocked <= 1'b0;
    end
    else if (busy)
    begin
      if (op_done)
      begin
        if (state == fpec_pkg::ST_PROG && ret_unlocked)
          state <= fpec_pkg::ST_UNLOCKED;
        else
          state <= fpec_pkg::ST_LOCKED;
      end
    end
    else if (prog_start)
    begin
      ret_unlocked <= (state == fpec_pkg::ST_UNLOCKED);
      state <= fpec_pkg::ST_PROG;
    end
    else if (erase_start)
      state <= fpec_pkg::ST_PAGE_ERASE;
    else if (mass_start)
      state <= fpec_pkg::ST_MASS_ERASE;
    else if (page_wr)
    begin
      if (state == fpec_pkg::ST_UNLOCKED && dbg_access)
        state <= fpec_pkg::ST_UNLOCKED;
      else if (state == fpec_pkg::ST_LOCKED || state == fpec_pkg::ST_PAGE_SET)
        state <= fpec_pkg::ST_PAGE_SET;
      else
        state <= fpec_pkg::ST_LOCKED;
    end
    else if (cmd_wr)
    begin
      if (state == fpec_pkg::ST_PAGE_SET && cmd == fpec_pkg::CMD_UNLOCK1)
        state <= fpec_pkg::ST_FIRST_KEY;
      else if (state == fpec_pkg::ST_FIRST_KEY && cmd == fpec_pkg::CMD_UNLOCK2)
        state <= fpec_pkg::ST_UNLOCKED;
      else
        state <= fpec_pkg::ST_LOCKED;
    end
  end

  // Lone byte held until its partner arrives; a byte of another word replaces it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_valid <= 1'b0;
      pend_hi <= 1'b0;
      pend_addr <= 16'h0000;
      pend_byte <= 8'h00;
    end
    else if (mem_we && !busy && !bypass)
    begin
      if (word_full)
        pend_valid <= 1'b0;
      else if (mem_be != 2'b00)
      begin
        pend_valid <= 1'b1;
        pend_hi <= mem_be[1];
        pend_addr <= mem_waddr;
        pend_byte <= mem_be[1] ? mem_wdata[15:8] : mem_wdata[7:0];
      end
    end
  end

  // Array drive; bypass hands the strobes to the pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fl_addr <= 16'h0000;
      fl_wdata <= fpec_pkg::ERASED_WORD;
      fl_prog <= 1'b0;
      fl_erase <= 1'b0;
      fl_mass <= 1'b0;
    end
    else if (bypass)
    begin
      fl_prog <= byp_sync[34];
      fl_erase <= byp_sync[33];
      fl_mass <= byp_sync[32];
      fl_addr <= byp_sync[31:16];
      fl_wdata <= byp_sync[15:0];
    end
    else
    begin
      if (prog_start)
      begin
        fl_addr <= mem_waddr;
        fl_wdata <= word_data;
      end
      else if (erase_start)
        fl_addr <= 16'(page_sel) << PAGE_WORDS_LOG2;
      fl_prog <= prog_start || (state == fpec_pkg::ST_PROG && !op_done);
      fl_erase <= erase_start || (state == fpec_pkg::ST_PAGE_ERASE && !op_done);
      fl_mass <= mass_start || (state == fpec_pkg::ST_MASS_ERASE && !op_done);
    end
  end

  // Stall and interrupt hold follow the running operation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_wait <= 1'b0;
      irq_hold <= 1'b0;
    end
    else
    begin
      mem_wait <= op_start || (busy && !op_done);
      irq_hold <= op_start || (busy && !op_done);
    end
  end

  // Read-protect hides array data from the debugger and the bypass pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dbg_rdata <= 16'h0000;
      byp_rdata <= 16'h0000;
    end
    else
    begin
      dbg_rdata <= rp_option ? 16'h0000 : fl_rdata;
      byp_rdata <= (rp_option || !bypass) ? 16'h0000 : fl_rdata;
    end
  end

  // Software-written registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sect <= fpec_pkg::SECT_RST;
      page <= fpec_pkg::PAGE_RST;
      freq_khz <= fpec_pkg::FREQ_RST;
      info_sel <= 1'b0;
    end
    else
    begin
      if (sect_wr)
        sect <= dbg_access ? pwdata[7:0] : (sect | pwdata[7:0]);
      // The page register is only loaded when the sequence allows it
      if (page_wr && !busy && (state != fpec_pkg::ST_UNLOCKED || dbg_access))
        page <= pwdata[15:0];
      if (wr_acc && paddr == fpec_pkg::ADDR_FREQ)
        freq_khz <= pwdata[15:0];
      if (wr_acc && paddr == fpec_pkg::ADDR_CTRL)
        info_sel <= pwdata[fpec_pkg::CTRL_INFO_BIT];
    end
  end

  always_comb
  begin
    unique case (state)
      fpec_pkg::ST_PROG: stat_code = fpec_pkg::STAT_PROG;
      fpec_pkg::ST_PAGE_ERASE: stat_code = fpec_pkg::STAT_PAGE;
      fpec_pkg::ST_MASS_ERASE: stat_code = fpec_pkg::STAT_MASS;
      default: stat_code = fpec_pkg::STAT_IDLE;
    endcase
    unlock_flag = (state == fpec_pkg::ST_UNLOCKED) || (state == fpec_pkg::ST_PROG && ret_unlocked);
  end

  // APB: data captured in the setup cycle so the access cycle ends at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          fpec_pkg::ADDR_CMD:
            prdata[7:0] <= {unlock_flag, 1'b0, stat_code};
          fpec_pkg::ADDR_CTRL: prdata[fpec_pkg::CTRL_INFO_BIT] <= info_sel;
          fpec_pkg::ADDR_SECT: prdata[7:0] <= sect;
          fpec_pkg::ADDR_PAGE: prdata[15:0] <= page;
          fpec_pkg::ADDR_FREQ: prdata[15:0] <= freq_khz;
          fpec_pkg::ADDR_OPT:
            prdata[2:0] <= {bypass, rp_option, wp_option};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  bad_key_lock_a: assert property (
    (state == fpec_pkg::ST_FIRST_KEY && cmd_wr && cmd != fpec_pkg::CMD_UNLOCK2
      && !(dbg_access && (cmd == fpec_pkg::CMD_PAGE_ERASE || cmd == fpec_pkg::CMD_MASS_ERASE)))
    |=> state == fpec_pkg::ST_LOCKED)
    else $error("wrong second key did not lock");

  unlock_seq_a: assert property (
    (state == fpec_pkg::ST_FIRST_KEY && cmd_wr && cmd == fpec_pkg::CMD_UNLOCK2
      && !prog_start)
    |=> state == fpec_pkg::ST_UNLOCKED)
    else $error("unlock sequence failed");

  lock_cmd_a: assert property (
    (state == fpec_pkg::ST_UNLOCKED && cmd_wr && cmd == fpec_pkg::CMD_LOCK && !prog_start)
    |=> state == fpec_pkg::ST_LOCKED)
    else $error("lock command ignored");

  sect_sticky_a: assert property (
    (sect_wr && !dbg_access) |=> ((sect & $past(sect)) == $past(sect)))
    else $error("user write cleared a protect bit");

  stall_op_a: assert property (
    (op_start && !bypass) |=> (mem_wait && irq_hold) [*2])
    else $error("reads not stalled during operation");

  erase_relock_a: assert property (
    (state == fpec_pkg::ST_PAGE_ERASE && op_done) |=> state == fpec_pkg::ST_LOCKED ##1 !mem_wait)
    else $error("page erase did not relock");

  wp_block_a: assert property (
    (wp_option && !dbg_access && cmd_wr && !busy) |=> state != fpec_pkg::ST_PAGE_ERASE)
    else $error("write protect ignored for erase");

  user_mass_a: assert property (
    (cmd_wr && !dbg_access && !busy && cmd == fpec_pkg::CMD_MASS_ERASE)
    |=> state == fpec_pkg::ST_LOCKED && !fl_mass)
    else $error("user code started mass erase");

  read_prot_a: assert property (
    rp_option |=> (dbg_rdata == 16'h0000 && byp_rdata == 16'h0000))
    else $error("protected data leaked");

  prot_sect_a: assert property (
    (cmd_wr && !dbg_access && !busy && !bypass && page_sect_prot) |=> !fl_erase)
    else $error("erase of protected sector");
endmodule

// *** dv/fpec_array_model.sv ***
`timescale 1ns/1ps
module fpec_array_model (
  input wire logic pclk, // System clock
  input wire logic [15:0] fl_addr, // Word address
  input wire logic [15:0] fl_wdata, // Program data
  input wire logic fl_prog, // Program strobe
  input wire logic fl_erase, // Page erase strobe
  input wire logic fl_mass, // Mass erase strobe
  output logic [15:0] fl_rdata // Read data
);
  logic [15:0] mem [0:65535];
  logic [2:0] prev = 3'h0;
  initial
  begin
    foreach (mem[i])
      mem[i] = 16'hffff;
  end
  assign fl_rdata = mem[fl_addr];
  // Strobes are levels, so act once on each rising edge only
  always @(posedge pclk)
  begin
    if (fl_prog && !prev[0])
      mem[fl_addr] <= mem[fl_addr] & fl_wdata;
    if (fl_erase && !prev[1])
      for (int i = 0; i < 1024; i++)
        mem[(fl_addr & 16'hfc00) + 16'(i)] <= 16'hffff;
    if (fl_mass && !prev[2])
      foreach (mem[i])
        mem[i] <= 16'hffff;
    prev <= {fl_mass, fl_erase, fl_prog};
  end
endmodule

// *** dv/fpec_top_tb_top.sv ***
`timescale 1ns/1ps
module fpec_top_tb_top;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, se, seen, ih, mem_wait, irq_hold, info_sel, fl_prog, fl_erase, fl_mass;
  logic dbg_access = 1'h0, wp_option = 1'h0, rp_option = 1'h0, mem_we = 1'h0;
  logic mem_dbg = 1'h0, bypass_pin = 1'h0, byp_prog_pin = 1'h0, byp_erase_pin = 1'h0;
  logic byp_mass_pin = 1'h0;
  logic [15:0] mem_waddr = 16'h0, mem_wdata = 16'h0, byp_addr_pin = 16'h0;
  logic [15:0] byp_wdata_pin = 16'h0, fl_addr, fl_wdata, fl_rdata, dbg_rdata, byp_rdata;
  logic [1:0] mem_be = 2'h0;
  int err_total = 0, check_count = 0;
  always #5 pclk = ~pclk;
  // Short op times keep the run small; freq 1 kHz gives one-cycle counts
  fpec_top #(.PROG_TIME_US(1), .PAGE_ERASE_TIME_US(1), .MASS_ERASE_TIME_US(1)) fpec_top_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .dbg_access, .wp_option, .rp_option, .mem_we, .mem_dbg, .mem_waddr,
    .mem_wdata, .mem_be, .mem_wait, .irq_hold, .info_sel, .fl_addr, .fl_wdata, .fl_prog,
    .fl_erase, .fl_mass, .fl_rdata, .dbg_rdata, .bypass_pin, .byp_prog_pin, .byp_erase_pin,
    .byp_mass_pin, .byp_addr_pin, .byp_wdata_pin, .byp_rdata);
  fpec_array_model fpec_array_model_i (.pclk, .fl_addr, .fl_wdata, .fl_prog, .fl_erase,
    .fl_mass, .fl_rdata);
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic cmd(input logic [7:0] c);
    acc(1'h1, fpec_pkg::ADDR_CMD, {24'h0, c});
  endtask
  task automatic st(input logic [7:0] e);
    acc(1'h0, fpec_pkg::ADDR_CMD, 32'h0);
    chk("status", {24'h0, e}, rd);
  endtask
  task automatic ul(input logic [15:0] p);
    cmd(8'h00);
    acc(1'h1, fpec_pkg::ADDR_PAGE, {16'h0, p});
    cmd(8'h73);
    cmd(8'h8c);
  endtask
  // Absence of an operation can only be shown by watching a window
  task automatic wq();
    seen = 1'h0;
    ih = 1'h0;
    repeat (40)
    begin
      @(posedge pclk);
      #1;
      if (irq_hold === 1'h1)
        ih = 1'h1;
      if (mem_wait === 1'h1)
        seen = 1'h1;
      else if (seen)
        break;
    end
  endtask
  task automatic mw(input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge pclk);
    mem_we <= 1'h1;
    mem_waddr <= a;
    mem_wdata <= d;
    mem_be <= be;
    @(posedge pclk);
    mem_we <= 1'h0;
    wq();
  endtask
  initial
  begin
    #100us;
    err_total++;
    final_report();
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    st(8'h00);
    acc(1'h0, fpec_pkg::ADDR_SECT, 32'h0);
    chk("sector", 32'h0, rd);
    acc(1'h1, fpec_pkg::ADDR_FREQ, 32'h1);
    acc(1'h0, fpec_pkg::ADDR_FREQ, 32'h0);
    chk("freq", 32'h1, rd);
    acc(1'h0, 12'h000, 32'h0);
    chk("slverr", 32'h1, {31'h0, se});
    mw(16'h0410, 16'h1234, 2'h3);
    chk("locked", 32'h0, {31'h0, seen});
    ul(16'h0001);
    st(8'h80);
    mw(16'h0410, 16'h1234, 2'h3);
    chk("prog", 32'h1, {31'h0, seen});
    chk("irq hold", 32'h1, {31'h0, ih});
    chk("word", 32'h1234, {16'h0, fpec_array_model_i.mem[16'h0410]});
    mw(16'h0411, 16'h00ab, 2'h1);
    chk("half", 32'h0, {31'h0, seen});
    mw(16'h0411, 16'hcd00, 2'h2);
    chk("pair", 32'hcdab, {16'h0, fpec_array_model_i.mem[16'h0411]});
    mw(16'h0800, 16'h0000, 2'h3);
    chk("off page", 32'h0, {31'h0, seen});
    cmd(8'h00);
    st(8'h00);
    acc(1'h1, fpec_pkg::ADDR_PAGE, 32'h1);
    cmd(8'h73);
    cmd(8'h55);
    st(8'h00);
    acc(1'h1, fpec_pkg::ADDR_SECT, 32'h1);
    acc(1'h1, fpec_pkg::ADDR_SECT, 32'h0);
    acc(1'h0, fpec_pkg::ADDR_SECT, 32'h0);
    chk("sticky", 32'h1, rd);
    ul(16'h0001);
    mw(16'h0412, 16'h0000, 2'h3);
    chk("prot prog", 32'h0, {31'h0, seen});
    cmd(8'h95);
    wq();
    chk("prot erase", 32'h0, {31'h0, seen});
    ul(16'h0008);
    mw(16'h2005, 16'h0000, 2'h3);
    cmd(8'h95);
    wq();
    chk("erase", 32'h1, {31'h0, seen});
    chk("erase hold", 32'h1, {31'h0, ih});
    chk("erased", 32'hffff, {16'h0, fpec_array_model_i.mem[16'h2005]});
    st(8'h00);
    ul(16'h0008);
    cmd(8'h63);
    wq();
    chk("user mass", 32'h0, {31'h0, seen});
    wp_option <= 1'h1;
    ul(16'h0008);
    mw(16'h2006, 16'h0000, 2'h3);
    chk("wp", 32'h0, {31'h0, seen});
    wp_option <= 1'h0;
    cmd(8'h00);
    dbg_access <= 1'h1;
    acc(1'h1, fpec_pkg::ADDR_SECT, 32'h0);
    acc(1'h0, fpec_pkg::ADDR_SECT, 32'h0);
    chk("dbg sector", 32'h0, rd);
    cmd(8'h63);
    wq();
    chk("dbg mass", 32'h1, {31'h0, seen});
    chk("mass", 32'hffff, {16'h0, fpec_array_model_i.mem[16'h0410]});
    // Debugger word write while locked and outside the selected page
    mem_dbg <= 1'h1;
    mw(16'h3000, 16'h5a5a, 2'h3);
    chk("dbg prog", 32'h5a5a, {16'h0, fpec_array_model_i.mem[16'h3000]});
    mem_dbg <= 1'h0;
    dbg_access <= 1'h0;
    acc(1'h1, fpec_pkg::ADDR_CTRL, 32'h80);
    acc(1'h0, fpec_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h80, rd);
    chk("info", 32'h1, {31'h0, info_sel});
    // Pins pass two sync stages and the output register
    bypass_pin <= 1'h1;
    byp_erase_pin <= 1'h1;
    byp_addr_pin <= 16'h2000;
    repeat (5) @(posedge pclk);
    chk("byp erase", 32'h1, {31'h0, fl_erase});
    chk("byp addr", 32'h2000, {16'h0, fl_addr});
    chk("byp rd", 32'hffff, {16'h0, byp_rdata});
    acc(1'h0, fpec_pkg::ADDR_OPT, 32'h0);
    chk("opt", 32'h4, rd);
    rp_option <= 1'h1;
    repeat (3) @(posedge pclk);
    chk("rp", 32'h0, {16'h0, dbg_rdata});
    chk("rp byp", 32'h0, {16'h0, byp_rdata});
    final_report();
  end
endmodule
